/* File: src/curve_pkg.sv */
package curve_pkg;
// Functional notes
// R1 - above the first knee use the upper slope, below it the lower slope
// R2 - gate region with expansion slope exists only while gate_enable (bit 7) is set
// R3 - gate off: second-knee fields and expansion ignored, lower slope below knee
// R4 - second_knee_output_enable (bit 4) adds a vertical drop before the gate region
// R5 - enable clear: second knee sits on the lower-slope line, no drop
// R6 - first knee point set by first-knee input and output level fields
// R7 - 0 dB output equals knee output minus knee input times upper slope
// R8 - compression slope 1 keeps gain, below 1 compresses, 0 holds output constant
// R9 - gate slope above 1 expands, slope 1 keeps constant gain
// R10 - gate expansion slope bits 7:6 code 1, 2, 4, 8; reset 00
// R11 - upper slope bits 5:3: 1 to 1/16, 101 is 0; reset 011
// R12 - lower slope bits 2:0: 1 to 1/8, 100 is 0; reset 000
// R13 - first-knee input bits 10:5, -0.75 dB per code down to -45 dB
// R14 - first-knee output bits 4:0, -0.75 dB per code down to -22.5 dB
// R15 - second-knee input bits 9:5, -36 dB minus 1.5 dB per code
// R16 - second-knee output bits 4:0, -30 dB minus 1.5 dB per code
// R17 - software enables the stage on one path only; path_select 0 record, 1 playback
// R18 - gain clamped between floor and ceiling, separate floor in gate region
// R19 - software never writes reserved codes; their effect is undefined

  // ****************************************
  // levels: one lsb is 0.75 dB / 16
  // ****************************************
  localparam int LEVEL_W = 16;
  localparam int EXT_W = 20;
  typedef logic signed [LEVEL_W-1:0] level_t;
  typedef logic signed [EXT_W-1:0] ext_t;
  typedef logic [15:0] reg16_t;
  localparam int STEP_SH = 4;
  localparam int STEP2_SH = 5;
  localparam ext_t K2IP_BASE = 20'sh300;
  localparam ext_t K2OP_BASE = 20'sh280;
  localparam ext_t DB6 = 20'sh00080;
  localparam ext_t DB12 = 20'sh00100;
  localparam ext_t DB18 = 20'sh00180;
  localparam ext_t DB24 = 20'sh00200;
  localparam ext_t DB36 = 20'sh00300;
  localparam logic [2:0] HI_ZERO = 3'h5;
  localparam logic [2:0] LO_ZERO = 3'h4;

  // ****************************************
  // register map (word index, byte = 4 x index)
  // ****************************************
  localparam int ADDR_W = 12;
  localparam int WORD_LSB = 2;
  typedef logic [ADDR_W-WORD_LSB-1:0] index_t;
  localparam index_t IDX_CTRL = 10'h114;
  localparam index_t IDX_LIMIT = 10'h115;
  localparam index_t IDX_SLOPE = 10'h116;
  localparam index_t IDX_KNEE1 = 10'h117;
  localparam index_t IDX_KNEE2 = 10'h118;
  localparam index_t IDX_STATUS = 10'h119;
  localparam index_t IDX_COUNT = 10'h11a;
  localparam index_t IDX_CLAMP = 10'h11b;
  localparam int ENA_B = 0, PATH_B = 1, K2OP_EN_B = 4, GATE_EN_B = 7;
  localparam int MAXG_L = 0, MING_L = 2, NGMIN_L = 12;
  localparam int LO_L = 0, HI_L = 3, EXP_L = 6;
  localparam int K1OP_L = 0, K1IP_L = 5, K2OP_L = 0, K2IP_L = 5;
  localparam int STAT_GATE_B = 31, STAT_ENA_B = 30, STAT_PATH_B = 29;
  localparam int CNT_HI_L = 16;
  localparam reg16_t CTRL_RST = 16'h0000, CTRL_WMASK = 16'h0093;
  localparam reg16_t LIMIT_RST = 16'h0005, LIMIT_WMASK = 16'h001f;
  localparam reg16_t SLOPE_RST = 16'h0018, SLOPE_WMASK = 16'hf0ff;
  localparam reg16_t KNEE1_RST = 16'h0000, KNEE1_WMASK = 16'h07ff;
  localparam reg16_t KNEE2_RST = 16'h0000, KNEE2_WMASK = 16'h03ff;
endpackage

/* File: src/curve_cfg_if.sv */
`timescale 1ns/100ps
// curve and limit settings from the register file to the two stages
interface curve_cfg_if;
  logic [5:0] k1ip;
  logic [4:0] k1op, k2ip, k2op;
  logic [2:0] hi, lo, ming;
  logic [1:0] ex, maxg;
  logic [3:0] ngmin;
  logic gate_en, k2op_en;
  modport ctrl(output k1ip, k1op, k2ip, k2op, hi, lo, ex, gate_en, k2op_en, ming, maxg, ngmin);
  modport curve(input k1ip, k1op, k2ip, k2op, hi, lo, ex, gate_en, k2op_en);
  modport limit(input ming, maxg, ngmin);
endinterface // curve_cfg_if

/* File: src/knee_curve.sv */
`timescale 1ns/100ps
module knee_curve (
  // clock and reset
  input logic pclk,
  input logic presetn,
  // settings
  curve_cfg_if.curve cfg,
  // measured level
  input logic in_valid,
  input curve_pkg::level_t in_level,
  // curve point
  output logic out_valid,
  output curve_pkg::ext_t out_x,
  output curve_pkg::ext_t out_y,
  output logic out_gate
);
  import curve_pkg::*;

  typedef struct packed {
    logic valid;
    ext_t x;
    ext_t y;
    logic gate;
  } state_t;
  state_t s_r, s_nxt;

  // slope n means 1/2^n; the zero code flattens the segment
  function automatic ext_t compress(ext_t d, logic [2:0] c, logic [2:0] zero_code);
    if (c == zero_code) return '0; // R8
    return d >>> c; // R11 R12
  endfunction

  // knee points, then the segment the level falls in
  always_comb begin
    ext_t k1i, k1o, k2i, k2o, knee2_y;
    k1i = -(ext_t'(cfg.k1ip) <<< STEP_SH); // R6 R13
    k1o = -(ext_t'(cfg.k1op) <<< STEP_SH); // R6 R14
    k2i = -K2IP_BASE - (ext_t'(cfg.k2ip) <<< STEP2_SH); // R15
    k2o = -K2OP_BASE - (ext_t'(cfg.k2op) <<< STEP2_SH); // R16
    knee2_y = cfg.k2op_en ? k2o : k1o + compress(k2i - k1i, cfg.lo, LO_ZERO); // R4 R5
    s_nxt.valid = in_valid;
    s_nxt.x = ext_t'(in_level);
    s_nxt.gate = 1'b0;
    // a 0 dB level lands on k1o - k1i*upper slope by construction
    if (s_nxt.x >= k1i) begin
      s_nxt.y = k1o + compress(s_nxt.x - k1i, cfg.hi, HI_ZERO); // R1 R7
    end else if (!cfg.gate_en || s_nxt.x >= k2i) begin
      s_nxt.y = k1o + compress(s_nxt.x - k1i, cfg.lo, LO_ZERO); // R1 R3
    end else begin
      s_nxt.y = knee2_y + ((s_nxt.x - k2i) <<< cfg.ex); // R2 R9 R10
      s_nxt.gate = 1'b1; // R2
    end
  end

  // one pipeline stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign out_valid = s_r.valid;
  assign out_x = s_r.x;
  assign out_y = s_r.y;
  assign out_gate = s_r.gate;
endmodule // knee_curve

/* File: src/gain_limit.sv */
`timescale 1ns/100ps
module gain_limit (
  // clock and reset
  input logic pclk,
  input logic presetn,
  // settings
  curve_cfg_if.limit cfg,
  // curve point
  input logic in_valid,
  input curve_pkg::ext_t in_x,
  input curve_pkg::ext_t in_y,
  input logic in_gate,
  // limited gain
  output logic out_valid,
  output curve_pkg::level_t out_gain,
  output curve_pkg::level_t out_target,
  output logic out_gate,
  output logic out_clamped
);
  import curve_pkg::*;

  typedef struct packed {
    logic valid;
    level_t gain;
    level_t target;
    logic gate;
    logic clamped;
  } state_t;
  state_t s_r, s_nxt;

  // floor from the region, ceiling applied last so it always holds
  always_comb begin
    ext_t g, fl, ce;
    g = in_y - in_x;
    case (cfg.ming)
      3'h0: fl = '0;
      3'h1: fl = -DB12;
      3'h2: fl = -DB18;
      3'h3: fl = -DB24;
      default: fl = -DB36;
    endcase
    if (in_gate) fl = ext_t'(ext_t'(cfg.ngmin) * DB6) - DB36; // R18
    case (cfg.maxg)
      2'h0: ce = DB12;
      2'h1: ce = DB18;
      2'h2: ce = DB24;
      default: ce = DB36;
    endcase
    s_nxt.clamped = 1'b0;
    if (g < fl) begin
      g = fl; // R18
      s_nxt.clamped = 1'b1;
    end
    if (g > ce) begin
      g = ce; // R18
      s_nxt.clamped = 1'b1;
    end
    s_nxt.valid = in_valid;
    s_nxt.gate = in_gate;
    s_nxt.gain = g[LEVEL_W-1:0];
    s_nxt.target = level_t'(in_x + g);
  end

  // one pipeline stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign out_valid = s_r.valid;
  assign out_gain = s_r.gain;
  assign out_target = s_r.target;
  assign out_gate = s_r.gate;
  assign out_clamped = s_r.clamped;
endmodule // gain_limit

/* File: src/dynamics_compressor_curve.sv */
`timescale 1ns/100ps
module dynamics_compressor_curve (
  // clock and reset
  input logic pclk,
  input logic presetn,
  // apb slave
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [curve_pkg::ADDR_W-1:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // record path level
  input logic rec_valid,
  input curve_pkg::level_t rec_level,
  // playback path level
  input logic play_valid,
  input curve_pkg::level_t play_level,
  // gain result
  output logic gain_valid,
  output curve_pkg::level_t gain_level,
  output curve_pkg::level_t target_level,
  output logic gate_active
);
  import curve_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    reg16_t ctrl_r;
    reg16_t limit_r;
    reg16_t slope_r;
    reg16_t knee1_r;
    reg16_t knee2_r;
    logic in_valid_r;
    level_t in_level_r;
    logic gain_valid_r;
    level_t gain_r;
    level_t target_r;
    logic gate_r;
    logic [15:0] sample_cnt_r;
    logic [15:0] gate_cnt_r;
    logic [15:0] clamp_cnt_r;
  } state_t;

  localparam state_t STATE_RST = '{
    pready_r: 1'b0,
    pslverr_r: 1'b0,
    prdata_r: 32'h0,
    ctrl_r: CTRL_RST,
    limit_r: LIMIT_RST,
    slope_r: SLOPE_RST,
    knee1_r: KNEE1_RST,
    knee2_r: KNEE2_RST,
    in_valid_r: 1'b0,
    in_level_r: '0,
    gain_valid_r: 1'b0,
    gain_r: '0,
    target_r: '0,
    gate_r: 1'b0,
    sample_cnt_r: 16'h0,
    gate_cnt_r: 16'h0,
    clamp_cnt_r: 16'h0
  };

  state_t s_r, s_nxt;

  // ****************************************
  // pipeline stages
  // ****************************************
  curve_cfg_if cif();

  logic cv_valid;
  ext_t cv_x;
  ext_t cv_y;
  logic cv_gate;
  logic lim_valid;
  level_t lim_gain;
  level_t lim_target;
  logic lim_gate;
  logic lim_clamped;

  // settings fan out straight from the registers
  assign cif.gate_en = s_r.ctrl_r[GATE_EN_B];
  assign cif.k2op_en = s_r.ctrl_r[K2OP_EN_B];
  assign cif.ex = s_r.slope_r[EXP_L +: 2];
  assign cif.hi = s_r.slope_r[HI_L +: 3];
  assign cif.lo = s_r.slope_r[LO_L +: 3];
  assign cif.ngmin = s_r.slope_r[NGMIN_L +: 4];
  assign cif.k1ip = s_r.knee1_r[K1IP_L +: 6];
  assign cif.k1op = s_r.knee1_r[K1OP_L +: 5];
  assign cif.k2ip = s_r.knee2_r[K2IP_L +: 5];
  assign cif.k2op = s_r.knee2_r[K2OP_L +: 5];
  assign cif.ming = s_r.limit_r[MING_L +: 3];
  assign cif.maxg = s_r.limit_r[MAXG_L +: 2];

  // level to curve point
  knee_curve u_curve (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(cif.curve),
    .in_valid(s_r.in_valid_r),
    .in_level(s_r.in_level_r),
    .out_valid(cv_valid),
    .out_x(cv_x),
    .out_y(cv_y),
    .out_gate(cv_gate)
  );

  // curve point to limited gain
  gain_limit u_limit (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(cif.limit),
    .in_valid(cv_valid),
    .in_x(cv_x),
    .in_y(cv_y),
    .in_gate(cv_gate),
    .out_valid(lim_valid),
    .out_gain(lim_gain),
    .out_target(lim_target),
    .out_gate(lim_gate),
    .out_clamped(lim_clamped)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    index_t idx;
    logic setup;
    logic wr_done;
    logic hit;
    logic clr_cnt;
    logic clr_clamp;
    logic path;
    logic [31:0] rd;
    s_nxt = s_r;
    idx = paddr[ADDR_W-1:WORD_LSB];
    setup = psel & ~penable;
    // the write lands on the edge where the master sees pready
    wr_done = psel & penable & s_r.pready_r & pwrite;
    clr_cnt = 1'b0;
    clr_clamp = 1'b0;
    hit = 1'b1;
    rd = 32'h0;
    path = s_r.ctrl_r[PATH_B]; // R17

    // read word for the addressed register
    case (idx)
      IDX_CTRL: rd[15:0] = s_r.ctrl_r;
      IDX_LIMIT: rd[15:0] = s_r.limit_r;
      IDX_SLOPE: rd[15:0] = s_r.slope_r;
      IDX_KNEE1: rd[15:0] = s_r.knee1_r;
      IDX_KNEE2: rd[15:0] = s_r.knee2_r;
      IDX_STATUS: begin
        rd[LEVEL_W-1:0] = s_r.gain_r;
        rd[STAT_GATE_B] = s_r.gate_r;
        rd[STAT_ENA_B] = s_r.ctrl_r[ENA_B];
        rd[STAT_PATH_B] = s_r.ctrl_r[PATH_B];
      end
      IDX_COUNT: rd = {s_r.gate_cnt_r, s_r.sample_cnt_r};
      IDX_CLAMP: rd = {s_r.target_r, s_r.clamp_cnt_r};
      default: hit = 1'b0;
    endcase

    // answer is registered in setup, so every access has one wait-free cycle
    s_nxt.pready_r = setup;
    s_nxt.pslverr_r = setup & ~hit;
    s_nxt.prdata_r = (setup & ~pwrite) ? rd : 32'h0;

    // register writes; reserved bits are kept at zero by the masks
    if (wr_done) begin
      case (idx)
        IDX_CTRL: s_nxt.ctrl_r = pwdata[15:0] & CTRL_WMASK; // R2 R4
        IDX_LIMIT: s_nxt.limit_r = pwdata[15:0] & LIMIT_WMASK; // R18
        IDX_SLOPE: s_nxt.slope_r = pwdata[15:0] & SLOPE_WMASK; // R10 R11 R12
        IDX_KNEE1: s_nxt.knee1_r = pwdata[15:0] & KNEE1_WMASK; // R13 R14
        IDX_KNEE2: s_nxt.knee2_r = pwdata[15:0] & KNEE2_WMASK; // R15 R16
        IDX_COUNT: clr_cnt = 1'b1;
        IDX_CLAMP: clr_clamp = 1'b1;
        default: clr_cnt = 1'b0;
      endcase
    end

    // one path feeds the curve; software keeps the other idle
    s_nxt.in_valid_r = s_r.ctrl_r[ENA_B] & (path ? play_valid : rec_valid);
    if (s_nxt.in_valid_r) begin
      s_nxt.in_level_r = path ? play_level : rec_level;
    end

    // result registers hold the last gain between samples
    s_nxt.gain_valid_r = lim_valid;
    if (lim_valid) begin
      s_nxt.gain_r = lim_gain;
      s_nxt.target_r = lim_target;
      s_nxt.gate_r = lim_gate;
    end

    // counters: a sample in the clearing cycle still counts
    s_nxt.sample_cnt_r = (clr_cnt ? 16'h0 : s_r.sample_cnt_r) + {15'h0, lim_valid};
    s_nxt.gate_cnt_r = (clr_cnt ? 16'h0 : s_r.gate_cnt_r) + {15'h0, lim_valid & lim_gate};
    s_nxt.clamp_cnt_r = (clr_clamp ? 16'h0 : s_r.clamp_cnt_r) + {15'h0, lim_valid & lim_clamped};
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from flops
  assign prdata = s_r.prdata_r;
  assign pready = s_r.pready_r;
  assign pslverr = s_r.pslverr_r;
  assign gain_valid = s_r.gain_valid_r;
  assign gain_level = s_r.gain_r;
  assign target_level = s_r.target_r;
  assign gate_active = s_r.gate_r;
endmodule // dynamics_compressor_curve

/* File: testbench/curve_asserts.sv */
`timescale 1ns/100ps
module curve_asserts
  import curve_pkg::*;
(
  // clock and reset
  input logic pclk,
  input logic presetn,
  // apb
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [ADDR_W-1:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  // levels in
  input logic rec_valid,
  input level_t rec_level,
  input logic play_valid,
  input level_t play_level,
  // gain out
  input logic gain_valid,
  input level_t gain_level,
  input level_t target_level,
  input logic gate_active
);
  // ****************************************
  // shadow of enable and limit settings
  // ****************************************
  logic [7:0] ctrl_r;
  logic [4:0] lim_r;
  logic wr_ok, take;
  level_t lvl, ceil_v, floor_v;
  // shadow follows completed writes only, so refused ones leave it alone
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  assign take = ctrl_r[0] && (ctrl_r[1] ? play_valid : rec_valid);
  assign lvl = ctrl_r[1] ? play_level : rec_level;
  assign ceil_v = (lim_r[1:0] == 2'h3) ? 16'sh0300 : level_t'(16'h0100 + 16'h0080 * lim_r[1:0]);
  assign floor_v = (lim_r[4:2] == 3'h0) ? 16'sh0000 : (lim_r[4:2] == 3'h4) ? -16'sh0300 :
    level_t'(-(16'h0080 * (lim_r[4:2] + 3'h1)));
  // register shadows
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= 8'h00;
      lim_r <= 5'h05;
    end else if (wr_ok && paddr[ADDR_W-1:WORD_LSB] == IDX_CTRL) begin
      ctrl_r <= pwdata[7:0];
    end else if (wr_ok && paddr[ADDR_W-1:WORD_LSB] == IDX_LIMIT) begin
      lim_r <= pwdata[4:0];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ready_setup_a: assert property (psel && !penable |=> pready) else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not idle");
  gain_latency_a: assert property (take |-> ##4 gain_valid) else $error("gain late");
  gain_cause_a: assert property (gain_valid |-> $past(take, 4)) else $error("gain uncaused");
  gain_hold_a: assert property (!gain_valid |-> $stable(gain_level) && $stable(target_level)
    && $stable(gate_active)) else $error("result moved");
  target_sum_a: assert property (gain_valid |-> target_level == level_t'($past(lvl, 4) + gain_level))
    else $error("target wrong");
  gain_ceil_a: assert property (gain_valid |-> gain_level <= ceil_v) else $error("above ceiling");
  gain_floor_a: assert property (gain_valid && !gate_active && lim_r[4:2] <= 3'h4 |-> gain_level >= floor_v)
    else $error("below floor");
  gate_off_a: assert property (gain_valid && !ctrl_r[7] |-> !gate_active) else $error("gate while off");
endmodule // curve_asserts

bind dynamics_compressor_curve curve_asserts chk_i (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .rec_valid(rec_valid),
  .rec_level(rec_level),
  .play_valid(play_valid),
  .play_level(play_level),
  .gain_valid(gain_valid),
  .gain_level(gain_level),
  .target_level(target_level),
  .gate_active(gate_active)
);

/* File: testbench/level_source.sv */
`timescale 1ns/100ps
module level_source
  import curve_pkg::*;
(
  // clock and reset
  input logic pclk,
  input logic presetn,
  // request
  input logic go,
  input logic path,
  input level_t lvl,
  // record path
  output logic rec_valid,
  output level_t rec_level,
  // playback path
  output logic play_valid,
  output level_t play_level
);
  // one sample on one path; idle lines toggle so stale data never matches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_valid <= 1'b0;
      play_valid <= 1'b0;
      rec_level <= 16'sh0000;
      play_level <= 16'sh0000;
    end else begin
      rec_valid <= go && !path;
      play_valid <= go && path;
      rec_level <= (go && !path) ? lvl : ~rec_level;
      play_level <= (go && path) ? lvl : ~play_level;
    end
  end
endmodule // level_source

/* File: testbench/dynamics_compressor_curve_bench.sv */
`timescale 1ns/100ps
module dynamics_compressor_curve_bench;
  import curve_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic go, path, rec_valid, play_valid, gain_valid, gate_active;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  level_t lvl, rec_level, play_level, gain_level, target_level;
  int n_fail, checked, cyc;

  dynamics_compressor_curve dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rec_valid(rec_valid),
    .rec_level(rec_level),
    .play_valid(play_valid),
    .play_level(play_level),
    .gain_valid(gain_valid),
    .gain_level(gain_level),
    .target_level(target_level),
    .gate_active(gate_active)
  );
  level_source src (
    .pclk(pclk),
    .presetn(presetn),
    .go(go),
    .path(path),
    .lvl(lvl),
    .rec_valid(rec_valid),
    .rec_level(rec_level),
    .play_valid(play_valid),
    .play_level(play_level)
  );

  // clock, and a cycle ceiling that cuts a hang short
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task report_and_stop;
    if (n_fail == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (e !== s) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  // apb transfer; held until pready is sampled high
  task xfer(input logic w, input index_t i, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait count assumed; only the cycle ceiling ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input index_t i, input logic [31:0] d);
    xfer(1'b1, i, d);
  endtask
  task rdchk(input string nm, input index_t i, input logic [31:0] e);
    xfer(1'b0, i, 32'h0);
    chk(nm, e, rd);
  endtask
  // one sample through the partner, then the result or its absence
  task smp(input level_t x, input logic p, input logic want, input level_t eg, input logic eq);
    int n;
    @(posedge pclk);
    go <= 1'b1;
    path <= p;
    lvl <= x;
    @(posedge pclk);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (gain_valid !== 1'b1 && n < 12);
    chk("gain_valid", want, gain_valid);
    if (want) begin
      chk("gain", eg, gain_level);
      chk("target", level_t'(x + eg), target_level);
      chk("gate", eq, gate_active);
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task t_reset;
    rdchk("ctrl", IDX_CTRL, 32'h0);
    rdchk("limit", IDX_LIMIT, 32'h5);
    rdchk("slope", IDX_SLOPE, 32'h18);
    rdchk("knee1", IDX_KNEE1, 32'h0);
    rdchk("knee2", IDX_KNEE2, 32'h0);
    xfer(1'b0, 10'h1ff, 32'h0);
    chk("unmapped", 32'h1, err);
  endtask
  // knee at -12 dB in, -6 dB out; 0 dB input on every upper slope
  task t_upper;
    wr(IDX_LIMIT, 32'h13);
    wr(IDX_KNEE1, 32'h208);
    wr(IDX_CTRL, 32'h1);
    for (int c = 0; c < 6; c++) begin
      wr(IDX_SLOPE, 32'(c << 3));
      smp(16'sh0, 1'b0, 1'b1, (c == 5) ? -16'sh80 : level_t'(-128 + (256 >>> c)), 1'b0);
    end
  endtask
  task t_lower;
    for (int c = 0; c < 5; c++) begin
      wr(IDX_SLOPE, 32'h18 | c);
      smp(-16'sh200, 1'b0, 1'b1, (c == 4) ? 16'sh180 : level_t'(384 + (-256 >>> c)), 1'b0);
    end
  endtask
  // -48 dB input under the gate, lower slope 1/2
  task t_gate;
    wr(IDX_KNEE2, 32'h0);
    wr(IDX_CTRL, 32'h81);
    for (int m = 0; m < 4; m++) begin
      wr(IDX_SLOPE, 32'(m << 6) | 32'h19);
      smp(-16'sh400, 1'b0, 1'b1, (m == 3) ? -16'sh300 : level_t'(640 - (256 << m)), 1'b1);
    end
    wr(IDX_KNEE2, 32'h80);
    smp(-16'sh400, 1'b0, 1'b1, -16'sh1c0, 1'b1);
    wr(IDX_CTRL, 32'h1);
    smp(-16'sh400, 1'b0, 1'b1, 16'sh200, 1'b0);
  endtask
  task t_knee2;
    wr(IDX_SLOPE, 32'h19);
    wr(IDX_KNEE2, 32'h2);
    wr(IDX_CTRL, 32'h91);
    smp(-16'sh400, 1'b0, 1'b1, 16'sh40, 1'b1);
    wr(IDX_CTRL, 32'h81);
    smp(-16'sh400, 1'b0, 1'b1, 16'sh180, 1'b1);
  endtask
  // wrong path drops the sample, both with the stage enabled and disabled
  task t_path;
    wr(IDX_CTRL, 32'h3);
    smp(16'sh0, 1'b1, 1'b1, -16'sh60, 1'b0);
    smp(16'sh0, 1'b0, 1'b0, 16'sh0, 1'b0);
    wr(IDX_CTRL, 32'h0);
    smp(16'sh0, 1'b1, 1'b0, 16'sh0, 1'b0);
  endtask
  task t_limit;
    wr(IDX_CTRL, 32'h1);
    wr(IDX_SLOPE, 32'h1c);
    smp(-16'sh600, 1'b0, 1'b1, 16'sh300, 1'b0);
    wr(IDX_LIMIT, 32'h10);
    smp(-16'sh600, 1'b0, 1'b1, 16'sh100, 1'b0);
    wr(IDX_LIMIT, 32'h3);
    wr(IDX_SLOPE, 32'h2c);
    smp(16'sh0, 1'b0, 1'b1, 16'sh0, 1'b0);
  endtask
  // status and counters after 23 samples, 7 gated, 4 clamped; then clears
  task t_status;
    rdchk("status", IDX_STATUS, 32'h4000_0000);
    rdchk("count", IDX_COUNT, 32'h0007_0017);
    rdchk("clamp", IDX_CLAMP, 32'h0000_0004);
    wr(IDX_STATUS, 32'hffff_ffff);
    chk("status_err", 32'h0, err);
    rdchk("status_kept", IDX_STATUS, 32'h4000_0000);
    wr(IDX_COUNT, 32'h0);
    wr(IDX_CLAMP, 32'h0);
    rdchk("count_clr", IDX_COUNT, 32'h0);
    rdchk("clamp_clr", IDX_CLAMP, 32'h0);
  endtask

  // main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    go = 1'b0;
    path = 1'b0;
    lvl = 16'sh0;
    n_fail = 0;
    checked = 0;
    cyc = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_upper();
    t_lower();
    t_gate();
    t_knee2();
    t_path();
    t_limit();
    t_status();
    report_and_stop();
  end
endmodule // dynamics_compressor_curve_bench
